// [design/ibmc_top.sv]
// input boost mixer control bank: axi4-lite slave holding the four mixer
// registers and registered control outputs to the analogue boost mixers.
// assumes the path enables come from logic on aclk, so they are not resynced.
//
// Contract
// - left mixer on by own bit or path
// - right mixer on by own bit or path
// - left mute bit silences left mixer output
// - right mute bit silences right mixer output
// - left pin gains: -12dB floor, 3dB steps
// - left pga gain eight uneven steps to 29dB
// - right pin gains use same mapping
// - right pga gain uses same steps
// - left source selects, pga selected at reset
// - right source selects, pga selected at reset
`timescale 1ns/100ps
module ibmc_top
	import ibmc_pkg::*;
(
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic              ce,
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [DATA_W-1:0] wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [DATA_W-1:0]      rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	input  wire logic              left_input_path_on,
	input  wire logic              right_input_path_on,
	output ibmc_side_t             left_boost_mixer,
	output ibmc_side_t             right_boost_mixer
);

	// bus state
	logic              awready_q, awready_d;
	logic              aw_full_q, aw_full_d;
	logic [ADDR_W-1:0] awaddr_q,  awaddr_d;
	logic              wready_q,  wready_d;
	logic              w_full_q,  w_full_d;
	logic [REG_W-1:0]  wdata_q,   wdata_d;
	logic [1:0]        wstrb_q,   wstrb_d;
	logic              bvalid_q,  bvalid_d;
	logic [1:0]        bresp_q,   bresp_d;
	logic              arready_q, arready_d;
	logic              rvalid_q,  rvalid_d;
	logic [DATA_W-1:0] rdata_q,   rdata_d;
	logic [1:0]        rresp_q,   rresp_d;
	logic              do_wr;

	// register file
	logic [REG_W-1:0]  ena_mute_q, ena_mute_d;
	logic [REG_W-1:0]  lgain_q,    lgain_d;
	logic [REG_W-1:0]  rgain_q,    rgain_d;
	logic [REG_W-1:0]  src_sel_q,  src_sel_d;

	// outputs to the analogue section
	ibmc_side_t        left_q,  left_d;
	ibmc_side_t        right_q, right_d;
	logic signed [5:0] l_pin2_db, l_pin3_db, r_pin2_db, r_pin3_db;
	logic        [5:0] l_pga_db,  r_pga_db;

	// only the two low byte lanes carry register bits
	function automatic logic [REG_W-1:0] merge(input logic [REG_W-1:0] old,
		input logic [REG_W-1:0] data, input logic [1:0] strb,
		input logic [REG_W-1:0] mask);
		logic [REG_W-1:0] lanes;
		lanes = {{8{strb[1]}}, {8{strb[0]}}};
		merge = ((old & ~lanes) | (data & lanes)) & mask;
	endfunction : merge

	function automatic logic hit(input logic [ADDR_W-1:0] a);
		hit = (a == ADDR_ENA_MUTE) || (a == ADDR_LEFT_GAIN) ||
			(a == ADDR_RIGHT_GAIN) || (a == ADDR_SRC_SEL);
	endfunction : hit

	assign do_wr = aw_full_q && w_full_q && !bvalid_q;

	// write and read channels; address and data may arrive in either order
	always_comb begin
		aw_full_d  = aw_full_q;
		awaddr_d   = awaddr_q;
		w_full_d   = w_full_q;
		wdata_d    = wdata_q;
		wstrb_d    = wstrb_q;
		bvalid_d   = bvalid_q;
		bresp_d    = bresp_q;
		rvalid_d   = rvalid_q;
		rdata_d    = rdata_q;
		rresp_d    = rresp_q;
		ena_mute_d = ena_mute_q;
		lgain_d    = lgain_q;
		rgain_d    = rgain_q;
		src_sel_d  = src_sel_q;
		if (awvalid && awready_q) begin
			aw_full_d = 1'b1;
			awaddr_d  = {awaddr[ADDR_W-1:2], 2'h0};
		end
		if (wvalid && wready_q) begin
			w_full_d = 1'b1;
			wdata_d  = wdata[REG_W-1:0];
			wstrb_d  = wstrb[1:0];
		end
		if (bvalid_q && bready) begin
			bvalid_d = 1'b0;
		end
		if (do_wr) begin
			aw_full_d = 1'b0;
			w_full_d  = 1'b0;
			bvalid_d  = 1'b1;
			// an unmapped address answers slverr and changes nothing
			bresp_d   = hit(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
			case (awaddr_q)
				ADDR_ENA_MUTE:   ena_mute_d = merge(ena_mute_q, wdata_q, wstrb_q,
					MASK_ENA_MUTE);
				ADDR_LEFT_GAIN:  lgain_d = merge(lgain_q, wdata_q, wstrb_q, MASK_GAIN);
				ADDR_RIGHT_GAIN: rgain_d = merge(rgain_q, wdata_q, wstrb_q, MASK_GAIN);
				ADDR_SRC_SEL:    src_sel_d = merge(src_sel_q, wdata_q, wstrb_q,
					MASK_SRC_SEL);
				default: begin
				end
			endcase
		end
		if (rvalid_q && rready) begin
			rvalid_d = 1'b0;
		end
		if (arvalid && arready_q) begin
			rvalid_d = 1'b1;
			rresp_d  = hit({araddr[ADDR_W-1:2], 2'h0}) ? RESP_OKAY : RESP_SLVERR;
			case ({araddr[ADDR_W-1:2], 2'h0})
				ADDR_ENA_MUTE:   rdata_d = {16'h0000, ena_mute_q};
				ADDR_LEFT_GAIN:  rdata_d = {16'h0000, lgain_q};
				ADDR_RIGHT_GAIN: rdata_d = {16'h0000, rgain_q};
				ADDR_SRC_SEL:    rdata_d = {16'h0000, src_sel_q};
				default:         rdata_d = 32'h0000_0000;
			endcase
		end
		// one write and one read in flight; readies are plain flops
		awready_d = !aw_full_d;
		wready_d  = !w_full_d;
		arready_d = !rvalid_d;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_q  <= 1'b0;
			aw_full_q  <= 1'b0;
			awaddr_q   <= '0;
			wready_q   <= 1'b0;
			w_full_q   <= 1'b0;
			wdata_q    <= '0;
			wstrb_q    <= 2'h0;
			bvalid_q   <= 1'b0;
			bresp_q    <= RESP_OKAY;
			arready_q  <= 1'b0;
			rvalid_q   <= 1'b0;
			rdata_q    <= '0;
			rresp_q    <= RESP_OKAY;
			ena_mute_q <= RST_ENA_MUTE;
			lgain_q    <= RST_GAIN;
			rgain_q    <= RST_GAIN;
			src_sel_q  <= RST_SRC_SEL;
		end else if (ce) begin
			awready_q  <= awready_d;
			aw_full_q  <= aw_full_d;
			awaddr_q   <= awaddr_d;
			wready_q   <= wready_d;
			w_full_q   <= w_full_d;
			wdata_q    <= wdata_d;
			wstrb_q    <= wstrb_d;
			bvalid_q   <= bvalid_d;
			bresp_q    <= bresp_d;
			arready_q  <= arready_d;
			rvalid_q   <= rvalid_d;
			rdata_q    <= rdata_d;
			rresp_q    <= rresp_d;
			ena_mute_q <= ena_mute_d;
			lgain_q    <= lgain_d;
			rgain_q    <= rgain_d;
			src_sel_q  <= src_sel_d;
		end
	end

	ibmc_gain_decode u_left_gain (
		.gain_reg (lgain_q),
		.pin2_db  (l_pin2_db),
		.pin3_db  (l_pin3_db),
		.pga_db   (l_pga_db)
	);

	ibmc_gain_decode u_right_gain (
		.gain_reg (rgain_q),
		.pin2_db  (r_pin2_db),
		.pin3_db  (r_pin3_db),
		.pga_db   (r_pga_db)
	);

	// outputs lag the register file by one cycle so every port is a flop
	always_comb begin
		left_d.on        = ena_mute_q[POS_LEFT_ON] | left_input_path_on;
		left_d.silence   = ena_mute_q[POS_LEFT_SILENCE];
		left_d.pin2_sel  = src_sel_q[POS_LEFT_PIN2_SEL];
		left_d.pin3_sel  = src_sel_q[POS_LEFT_PIN3_SEL];
		left_d.pga_sel   = src_sel_q[POS_LEFT_PGA_SEL];
		left_d.pin2_db   = l_pin2_db;
		left_d.pin3_db   = l_pin3_db;
		left_d.pga_db    = l_pga_db;
		right_d.on       = ena_mute_q[POS_RIGHT_ON] | right_input_path_on;
		right_d.silence  = ena_mute_q[POS_RIGHT_SILENCE];
		right_d.pin2_sel = src_sel_q[POS_RIGHT_PIN2_SEL];
		right_d.pin3_sel = src_sel_q[POS_RIGHT_PIN3_SEL];
		right_d.pga_sel  = src_sel_q[POS_RIGHT_PGA_SEL];
		right_d.pin2_db  = r_pin2_db;
		right_d.pin3_db  = r_pin3_db;
		right_d.pga_db   = r_pga_db;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			left_q  <= SIDE_RST;
			right_q <= SIDE_RST;
		end else if (ce) begin
			left_q  <= left_d;
			right_q <= right_d;
		end
	end

	assign awready           = awready_q;
	assign wready            = wready_q;
	assign bvalid            = bvalid_q;
	assign bresp             = bresp_q;
	assign arready           = arready_q;
	assign rvalid            = rvalid_q;
	assign rdata             = rdata_q;
	assign rresp             = rresp_q;
	assign left_boost_mixer  = left_q;
	assign right_boost_mixer = right_q;

	left_on_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ce |=> left_q.on == ($past(ena_mute_q[POS_LEFT_ON]) | $past(left_input_path_on)))
		else $error("left mixer enable wrong");

	right_on_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && !ena_mute_q[POS_RIGHT_ON] && !right_input_path_on |=> !right_q.on)
		else $error("right mixer on without cause");

	left_mute_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && do_wr && awaddr_q == ADDR_ENA_MUTE && wstrb_q[0] ##1 ce
		|=> left_q.silence == $past(wdata_q[POS_LEFT_SILENCE], 2))
		else $error("left mute does not follow write");

	right_mute_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ce |=> right_q.silence == $past(ena_mute_q[POS_RIGHT_SILENCE]))
		else $error("right mute wrong");

	left_pin_gain_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && lgain_q[POS_PIN2_GAIN +: 3] <= 3'h1 |=> left_q.pin2_db == 6'sh34)
		else $error("left pin2 floor not -12dB");

	left_pga_gain_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && lgain_q[POS_PGA_GAIN +: 3] == 3'h2 |=> left_q.pga_db == 6'h0d)
		else $error("left pga step 2 not 13dB");

	right_pin_gain_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && rgain_q[POS_PIN3_GAIN +: 3] == 3'h5 |=> right_q.pin3_db == 6'sh00)
		else $error("right pin3 code 5 not 0dB");

	right_pga_gain_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && rgain_q[POS_PGA_GAIN +: 3] == 3'h7 |=> right_q.pga_db == 6'h1d)
		else $error("right pga top not 29dB");

	left_select_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ce |=> {left_q.pin2_sel, left_q.pin3_sel, left_q.pga_sel}
			== $past(src_sel_q[POS_LEFT_PGA_SEL +: 3]))
		else $error("left selects wrong");

	right_select_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ce |=> {right_q.pin2_sel, right_q.pin3_sel, right_q.pga_sel}
			== $past(src_sel_q[POS_RIGHT_PGA_SEL +: 3]))
		else $error("right selects wrong");

	unused_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
		rvalid_q |-> rdata_q[DATA_W-1:REG_W] == '0
			&& (ena_mute_q & ~MASK_ENA_MUTE) == '0 && (src_sel_q & ~MASK_SRC_SEL) == '0
			&& ((lgain_q | rgain_q) & ~MASK_GAIN) == '0)
		else $error("unused bits not zero");

	regs_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!(ce && do_wr) |=> $stable({ena_mute_q, lgain_q, rgain_q, src_sel_q}))
		else $error("register changed without write");

endmodule : ibmc_top

// [design/ibmc_pkg.sv]
// package for the input boost mixer control bank: register map, field layout,
// reset values and the packed carrier that goes to the analogue section.
// assumes a 32-bit axi4-lite register bus with byte addresses of 8 bits.
package ibmc_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int REG_W  = 16;

	// register indices; the byte address is four times the index
	localparam logic [5:0] IDX_ENA_MUTE  = 6'h1f;
	localparam logic [5:0] IDX_LEFT_GAIN = 6'h20;
	localparam logic [5:0] IDX_RIGHT_GAIN = 6'h21;
	localparam logic [5:0] IDX_SRC_SEL   = 6'h22;

	localparam logic [ADDR_W-1:0] ADDR_ENA_MUTE   = {IDX_ENA_MUTE, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_LEFT_GAIN  = {IDX_LEFT_GAIN, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_RIGHT_GAIN = {IDX_RIGHT_GAIN, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_SRC_SEL    = {IDX_SRC_SEL, 2'h0};

	// implemented bits of each register
	localparam logic [REG_W-1:0] MASK_ENA_MUTE = 16'h000f;
	localparam logic [REG_W-1:0] MASK_GAIN     = 16'h01ff;
	localparam logic [REG_W-1:0] MASK_SRC_SEL  = 16'h003f;

	// values after reset
	localparam logic [REG_W-1:0] RST_ENA_MUTE = 16'h0000;
	localparam logic [REG_W-1:0] RST_GAIN     = 16'h0145;
	localparam logic [REG_W-1:0] RST_SRC_SEL  = 16'h0009;

	// field positions in the enable and mute register
	localparam int POS_LEFT_ON       = 1;
	localparam int POS_RIGHT_ON      = 0;
	localparam int POS_LEFT_SILENCE  = 3;
	localparam int POS_RIGHT_SILENCE = 2;

	// field positions in the gain registers (low bit of each 3-bit code)
	localparam int POS_PIN2_GAIN = 6;
	localparam int POS_PGA_GAIN  = 3;
	localparam int POS_PIN3_GAIN = 0;

	// field positions in the source select register
	localparam int POS_LEFT_PIN2_SEL  = 5;
	localparam int POS_LEFT_PIN3_SEL  = 4;
	localparam int POS_LEFT_PGA_SEL   = 3;
	localparam int POS_RIGHT_PIN2_SEL = 2;
	localparam int POS_RIGHT_PIN3_SEL = 1;
	localparam int POS_RIGHT_PGA_SEL  = 0;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// gains are whole dB; pin gains two's complement, pga gain unsigned
	typedef struct packed {
		logic              on;
		logic              silence;
		logic              pin2_sel;
		logic              pin3_sel;
		logic              pga_sel;
		logic signed [5:0] pin2_db;
		logic signed [5:0] pin3_db;
		logic        [5:0] pga_db;
	} ibmc_side_t;

	localparam ibmc_side_t SIDE_RST = '{on: 1'b0, silence: 1'b0, pin2_sel: 1'b0,
		pin3_sel: 1'b0, pga_sel: 1'b1, pin2_db: 6'h00, pin3_db: 6'h00, pga_db: 6'h00};

endpackage : ibmc_pkg

// [design/ibmc_gain_decode.sv]
// gain decoder for one boost mixer: turns the 9-bit gain register into dB.
// purely combinational; the caller registers the result.
`timescale 1ns/100ps
module ibmc_gain_decode
	import ibmc_pkg::*;
(
	input  wire logic        [REG_W-1:0] gain_reg,
	output logic signed      [5:0]       pin2_db,
	output logic signed      [5:0]       pin3_db,
	output logic             [5:0]       pga_db
);

	// codes 000 and 001 both give the floor of -12 dB
	function automatic logic [5:0] pin_db(input logic [2:0] code);
		case (code)
			3'h0, 3'h1: pin_db = 6'h34;
			3'h2:       pin_db = 6'h37;
			3'h3:       pin_db = 6'h3a;
			3'h4:       pin_db = 6'h3d;
			3'h5:       pin_db = 6'h00;
			3'h6:       pin_db = 6'h03;
			default:    pin_db = 6'h06;
		endcase
	endfunction : pin_db

	// pga path steps are uneven, so a table and not arithmetic
	function automatic logic [5:0] pga_steps(input logic [2:0] code);
		case (code)
			3'h0:    pga_steps = 6'h00;
			3'h1:    pga_steps = 6'h06;
			3'h2:    pga_steps = 6'h0d;
			3'h3:    pga_steps = 6'h12;
			3'h4:    pga_steps = 6'h14;
			3'h5:    pga_steps = 6'h18;
			3'h6:    pga_steps = 6'h1b;
			default: pga_steps = 6'h1d;
		endcase
	endfunction : pga_steps

	always_comb begin
		pin2_db = pin_db(gain_reg[POS_PIN2_GAIN +: 3]);
		pin3_db = pin_db(gain_reg[POS_PIN3_GAIN +: 3]);
		pga_db  = pga_steps(gain_reg[POS_PGA_GAIN +: 3]);
	end

endmodule : ibmc_gain_decode

// [verification/test_input_boost_mixer_control.sv]
// self-checking bench for the input boost mixer control bank.
// assumes ibmc_pkg and ibmc_top are compiled first; bench drives the axi4-lite port itself.
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin n_compared++; if ((ex) !== (got)) begin err_count++; \
	$display("wrong value %s expected %0h seen %0h", nm, ex, got); end end
module test_input_boost_mixer_control
	import ibmc_pkg::*;
;
	logic              aclk;
	logic              aresetn;
	logic              ce;
	logic [ADDR_W-1:0] awaddr;
	logic              awvalid;
	logic              awready;
	logic [DATA_W-1:0] wdata;
	logic [3:0]        wstrb;
	logic              wvalid;
	logic              wready;
	logic [1:0]        bresp;
	logic              bvalid;
	logic              bready;
	logic [ADDR_W-1:0] araddr;
	logic              arvalid;
	logic              arready;
	logic [DATA_W-1:0] rdata;
	logic [1:0]        rresp;
	logic              rvalid;
	logic              rready;
	logic              left_input_path_on;
	logic              right_input_path_on;
	ibmc_side_t        left_boost_mixer;
	ibmc_side_t        right_boost_mixer;
	int                err_count;
	int                n_compared;
	logic [1:0]        bq [$];
	logic [33:0]       rq [$];
	logic [1:0]        eb;
	logic [33:0]       er;
	// bench copy of the four registers, in address order
	logic [REG_W-1:0]  m [4] = '{16'h0000, 16'h0145, 16'h0145, 16'h0009};
	logic [REG_W-1:0]  msk [4] = '{16'h000f, 16'h01ff, 16'h01ff, 16'h003f};
	logic [ADDR_W-1:0] adr [4] = '{ADDR_ENA_MUTE, ADDR_LEFT_GAIN, ADDR_RIGHT_GAIN, ADDR_SRC_SEL};
	logic [5:0]        pga_tab [8] = '{6'h00, 6'h06, 6'h0d, 6'h12, 6'h14, 6'h18, 6'h1b, 6'h1d};
	logic [DATA_W-1:0] d;
	int                k;

	ibmc_top dut_u (.aclk(aclk), .aresetn(aresetn), .ce(ce), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .left_input_path_on(left_input_path_on),
		.right_input_path_on(right_input_path_on), .left_boost_mixer(left_boost_mixer),
		.right_boost_mixer(right_boost_mixer));

	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end

	function automatic int find(input logic [ADDR_W-1:0] a);
		for (int i = 0; i < 4; i++)
			if (adr[i][ADDR_W-1:2] == a[ADDR_W-1:2]) return i;
		return -1;
	endfunction : find

	function automatic logic signed [5:0] pin_db(input logic [2:0] c);
		int v;
		v = (c < 3'h2) ? -12 : 3 * int'(c) - 15;
		return 6'(v);
	endfunction : pin_db

	function automatic ibmc_side_t exp_side(input bit lft);
		ibmc_side_t       e;
		logic [REG_W-1:0] g;
		g = lft ? m[1] : m[2];
		e.on = lft ? (m[0][1] | left_input_path_on) : (m[0][0] | right_input_path_on);
		e.silence = lft ? m[0][3] : m[0][2];
		e.pin2_sel = lft ? m[3][5] : m[3][2];
		e.pin3_sel = lft ? m[3][4] : m[3][1];
		e.pga_sel = lft ? m[3][3] : m[3][0];
		e.pin2_db = pin_db(g[8:6]);
		e.pin3_db = pin_db(g[2:0]);
		e.pga_db = pga_tab[g[5:3]];
		return e;
	endfunction : exp_side

	task automatic chk_outs();
		@(posedge aclk);
		#1;
		`CHK("left mixer", exp_side(1'b1), left_boost_mixer)
		`CHK("right mixer", exp_side(1'b0), right_boost_mixer)
	endtask : chk_outs

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] dv,
		input logic [3:0] s);
		int               i;
		logic [REG_W-1:0] nv;
		i = find(a);
		bq.push_back(i < 0 ? RESP_SLVERR : RESP_OKAY);
		@(posedge aclk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= dv;
		wstrb <= s;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge aclk);
			// outputs must keep the old settings until the write has completed
			`CHK("left hold", exp_side(1'b1), left_boost_mixer)
			`CHK("right hold", exp_side(1'b0), right_boost_mixer)
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid && bready) break;
		end
		bready <= 1'b0;
		if (i >= 0) begin
			nv = m[i];
			if (s[0]) nv[7:0] = dv[7:0];
			if (s[1]) nv[15:8] = dv[15:8];
			m[i] = nv & msk[i];
		end
	endtask : wr

	task automatic rd(input logic [ADDR_W-1:0] a);
		int i;
		i = find(a);
		rq.push_back(i < 0 ? {RESP_SLVERR, 32'h0} : {RESP_OKAY, 16'h0, m[i]});
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid && rready) break;
		end
		rready <= 1'b0;
	endtask : rd

	// response watcher: compares each answer with the oldest note
	always @(posedge aclk) begin
		if (bvalid && bready) begin
			eb = (bq.size() > 0) ? bq.pop_front() : 2'h3;
			`CHK("bresp", eb, bresp)
		end
		if (rvalid && rready) begin
			er = (rq.size() > 0) ? rq.pop_front() : 34'h3_ffff_ffff;
			`CHK("read", er, {rresp, rdata})
		end
	end

	task automatic end_sim();
		$display("mismatches %0d comparisons %0d", err_count, n_compared);
		if (err_count == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : end_sim

	// whole run is well under 1000 cycles
	initial begin
		#2_000_000;
		err_count++;
		end_sim();
	end

	initial begin
		err_count = 0;
		n_compared = 0;
		aresetn = 1'b0;
		ce = 1'b1;
		awaddr = '0;
		awvalid = 1'b0;
		wdata = '0;
		wstrb = '0;
		wvalid = 1'b0;
		bready = 1'b0;
		araddr = '0;
		arvalid = 1'b0;
		rready = 1'b0;
		left_input_path_on = 1'b0;
		right_input_path_on = 1'b0;
		void'($urandom(31));
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		chk_outs();
		for (k = 0; k < 4; k++) rd(adr[k]);
		// every gain code in every field, junk in the unused bits
		for (k = 0; k < 8; k++) begin
			d = $urandom;
			d[8:0] = {3'(k), 3'(~k), 3'(k + 3)};
			wr(ADDR_LEFT_GAIN, d, 4'hf);
			d[8:0] = {3'(k + 5), 3'(k), 3'(~k)};
			wr(ADDR_RIGHT_GAIN, d, 4'hf);
			chk_outs();
			rd(ADDR_LEFT_GAIN);
			rd(ADDR_RIGHT_GAIN);
		end
		// enables and mutes against random path enables
		for (k = 0; k < 16; k++) begin
			@(posedge aclk);
			// paths go quiet while the mute bits change, so the write cannot pop
			left_input_path_on <= 1'b0;
			right_input_path_on <= 1'b0;
			d = $urandom;
			d[3:0] = 4'(k);
			wr(ADDR_ENA_MUTE, d, 4'hf);
			left_input_path_on <= 1'($urandom);
			right_input_path_on <= 1'($urandom);
			chk_outs();
			rd(ADDR_ENA_MUTE);
		end
		// path enable alone turns the mixer on, no write needed
		wr(ADDR_ENA_MUTE, 32'h0, 4'hf);
		for (k = 0; k < 4; k++) begin
			@(posedge aclk);
			left_input_path_on <= k[0];
			right_input_path_on <= k[1];
			@(posedge aclk);
			chk_outs();
		end
		// ce low freezes the outputs although both path enables drop
		@(posedge aclk);
		ce <= 1'b0;
		left_input_path_on <= 1'b0;
		right_input_path_on <= 1'b0;
		repeat (3) @(posedge aclk);
		#1;
		`CHK("frozen left", 1'b1, left_boost_mixer.on)
		`CHK("frozen right", 1'b1, right_boost_mixer.on)
		@(posedge aclk);
		ce <= 1'b1;
		chk_outs();
		for (k = 0; k < 8; k++) begin
			wr(ADDR_SRC_SEL, $urandom, 4'hf);
			chk_outs();
			rd(ADDR_SRC_SEL);
		end
		// byte lanes: only lanes 0 and 1 carry register bits
		wr(ADDR_LEFT_GAIN, $urandom, 4'h1);
		rd(ADDR_LEFT_GAIN);
		wr(ADDR_LEFT_GAIN, $urandom, 4'h2);
		rd(ADDR_LEFT_GAIN);
		wr(ADDR_LEFT_GAIN, $urandom, 4'hc);
		chk_outs();
		// unmapped places refuse and change nothing
		wr(8'h90, $urandom, 4'hf);
		wr(8'h00, $urandom, 4'hf);
		chk_outs();
		rd(8'h90);
		rd(8'h78);
		for (k = 0; k < 4; k++) rd(adr[k]);
		repeat (4) @(posedge aclk);
		// a second reset in mid-run brings back every reset value
		aresetn <= 1'b0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		m = '{16'h0000, 16'h0145, 16'h0145, 16'h0009};
		chk_outs();
		for (k = 0; k < 4; k++) rd(adr[k]);
		repeat (4) @(posedge aclk);
		if (bq.size() != 0 || rq.size() != 0) err_count++;
		end_sim();
	end
endmodule : test_input_boost_mixer_control
